// File: design/prmc_ctrl.sv
// power reduction mode controller: mode field, clock gating, wake-up
// decision and oscillator stabilisation wait; apb slave for registers
// assumes wake inputs are asynchronous pins, apb on i_clk
//
// How it works
// - mode 00 gives normal running, default
// - mode 01 halts cpu, peripherals keep running
// - enabled interrupt or reset ends idle
// - mode 10 stops main oscillator
// - listed resets and interrupts end power-down
// - interrupt wake needs enabled source and global enable; enabled reset sources wake without it
// - rc oscillator off unless clocking rtc
// - restart oscillator, wait 1024 or 256 clocks
// - watchdog runs if its clock select set
// - comparators on unless powered down and disabled
// - rtc and its crystal run unless rtc_power_down
// - brownout stays active in mode 10 unless pwr_ctrl bit 5 is set
// - mode 11 also disables brownout and comparators
// - mode field bits 1:0, reset to 0
//
// The placing of the registers and the APB slave port are this design's own decisions.
`timescale 1ns/1ps
`include "prmc_map.svh"
module prmc_ctrl #(
  parameter int CNT_W = `PRMC_CNT_W,
  parameter int XTAL_CYCLES = `PRMC_XTAL_CYCLES,
  parameter int RC_CYCLES = `PRMC_RC_CYCLES
) (
  input wire logic i_clk,
  input wire logic i_arst_n,
  input wire logic i_ce,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [11:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  input wire logic i_ext_int_pins,
  input wire logic i_kbd_int,
  input wire logic i_rtc_int,
  input wire logic i_wdt_int,
  input wire logic i_wdt_rst,
  input wire logic i_bod_event,
  input wire logic i_cmp_int,
  input wire logic i_ext_rst,
  input wire logic i_wdt_clk_sel,
  input wire logic i_rtc_enabled,
  input wire logic i_clk_sel_rc,
  input wire logic i_clk_sel_xtal,
  input wire logic i_cmp_enabled,
  input wire logic i_bod_int_sel,
  output logic o_cpu_clk_en,
  output logic o_osc_en,
  output logic o_rc_osc_en,
  output logic o_periph_clk_en,
  output logic o_wdt_run,
  output logic o_cmp_power,
  output logic o_rtc_run,
  output logic o_bod_active,
  output logic o_wake_irq,
  output logic o_wake_rst
);
  localparam int NSRC = 9;
  if (CNT_W < $clog2(XTAL_CYCLES + 1) || CNT_W < $clog2(RC_CYCLES + 1)) begin
    $error("CNT_W too narrow for stabilisation counts");
  end
  if (RC_CYCLES < 2 || XTAL_CYCLES < 2) begin
    $error("stabilisation counts must be at least 2");
  end

  typedef struct packed {
    logic [7:0] pwr_ctrl;
    logic [7:0] pwr_ctrl_a;
    logic [15:0] wake_en;
    prmc_pkg::prmc_state_t state;
    logic [NSRC-1:0] sync1;
    logic [NSRC-1:0] sync2;
    logic load;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic cpu_clk_en;
    logic osc_en;
    logic rc_osc_en;
    logic periph_clk_en;
    logic wdt_run;
    logic cmp_power;
    logic rtc_run;
    logic bod_active;
    logic wake_irq;
    logic wake_rst;
  } prmc_st_t;
  prmc_st_t st_reg;
  prmc_st_t st_next;
  logic stab_done;

  // wake source index into sync vectors and enable bits
  localparam int S_EXT = `PRMC_WAKE_EXT_BIT;
  localparam int S_KBD = `PRMC_WAKE_KBD_BIT;
  localparam int S_RTC = `PRMC_WAKE_RTC_BIT;
  localparam int S_WDI = `PRMC_WAKE_WDI_BIT;
  localparam int S_BOI = `PRMC_WAKE_BOI_BIT;
  localparam int S_CMP = `PRMC_WAKE_CMP_BIT;
  localparam int S_WDR = `PRMC_WAKE_WDR_BIT;
  localparam int S_BOR = `PRMC_WAKE_BOR_BIT;
  localparam int S_XRS = `PRMC_WAKE_XRS_BIT;
  localparam int GIE_BIT = `PRMC_GIE_BIT;

  wire logic [NSRC-1:0] raw_in = {i_ext_rst, i_bod_event, i_wdt_rst, i_cmp_int, i_bod_event,
                                  i_wdt_int, i_rtc_int, i_kbd_int, i_ext_int_pins};

  function automatic logic reg_hit(input logic [11:0] a, input logic [11:0] ofs);
    reg_hit = (a[11:2] == ofs[11:2]);
  endfunction

  prmc_stab_timer #(.CNT_W(CNT_W)) prmc_stab_timer_inst (
    .i_clk(i_clk),
    .i_arst_n(i_arst_n),
    .i_ce(i_ce),
    .i_load(st_reg.load),
    .i_load_val(i_clk_sel_xtal ? CNT_W'(XTAL_CYCLES) : CNT_W'(RC_CYCLES)),
    .o_done(stab_done)
  );

  logic [1:0] mode;
  logic total_pd;
  logic bod_on;
  logic cmp_on;
  logic [NSRC-1:0] src_ok;
  logic irq_wake;
  logic rst_wake;
  logic acc;

  always_comb begin
    mode = st_reg.pwr_ctrl[`PRMC_MODE_LSB +: 2];
    total_pd = (mode == prmc_pkg::PRMC_MODE_TOTAL_PD);
    bod_on = !total_pd && !st_reg.pwr_ctrl[`PRMC_BOPD_BIT];
    cmp_on = !total_pd &&
             !(st_reg.pwr_ctrl_a[`PRMC_CMP_PD_BIT] && !i_cmp_enabled);
    src_ok = st_reg.sync2 & st_reg.wake_en[NSRC-1:0];
    src_ok[S_BOI] = src_ok[S_BOI] & bod_on & i_bod_int_sel;
    src_ok[S_BOR] = src_ok[S_BOR] & bod_on & !i_bod_int_sel;
    src_ok[S_CMP] = src_ok[S_CMP] & cmp_on;
    irq_wake = |src_ok[S_CMP:S_EXT] && st_reg.wake_en[GIE_BIT];
    rst_wake = |src_ok[S_XRS:S_WDR];
    acc = i_psel && i_penable && !st_reg.pready;
  end

  always_comb begin
    st_next = st_reg;
    st_next.sync1 = raw_in;
    st_next.sync2 = st_reg.sync1;
    st_next.load = 1'b0;
    st_next.pready = 1'b0;
    st_next.pslverr = 1'b0;
    st_next.wake_irq = 1'b0;
    st_next.wake_rst = 1'b0;
    if (acc) begin
      st_next.pready = 1'b1;
      st_next.prdata = '0;
      if (reg_hit(i_paddr, `PRMC_PWR_CTRL_OFS)) begin
        st_next.prdata[7:0] = st_reg.pwr_ctrl;
        if (i_pwrite) st_next.pwr_ctrl = i_pwdata[7:0];
      end else if (reg_hit(i_paddr, `PRMC_PWR_CTRL_A_OFS)) begin
        st_next.prdata[7:0] = st_reg.pwr_ctrl_a;
        if (i_pwrite) st_next.pwr_ctrl_a = i_pwdata[7:0];
      end else if (reg_hit(i_paddr, `PRMC_WAKE_EN_OFS)) begin
        st_next.prdata[15:0] = st_reg.wake_en;
        if (i_pwrite) st_next.wake_en = i_pwdata[15:0];
      end else if (reg_hit(i_paddr, `PRMC_STATUS_OFS)) begin
        st_next.prdata[1:0] = st_reg.state;
        st_next.prdata[`PRMC_STAT_DONE_BIT] = stab_done;
      end else begin
        st_next.pslverr = 1'b1;
      end
    end
    case (st_reg.state)
      prmc_pkg::PRMC_RUN: begin
        if (mode == prmc_pkg::PRMC_MODE_IDLE) st_next.state = prmc_pkg::PRMC_IDLE;
        else if (mode[1]) st_next.state = prmc_pkg::PRMC_DOWN;
      end
      prmc_pkg::PRMC_IDLE: begin
        if (irq_wake || rst_wake) begin
          st_next.state = prmc_pkg::PRMC_RUN;
          st_next.pwr_ctrl[`PRMC_MODE_LSB +: 2] = 2'h0;
          st_next.wake_irq = irq_wake && !rst_wake;
          st_next.wake_rst = rst_wake;
        end
      end
      prmc_pkg::PRMC_DOWN: begin
        if (irq_wake || rst_wake) begin
          st_next.state = prmc_pkg::PRMC_STARTUP;
          st_next.load = 1'b1;
          st_next.wake_irq = irq_wake && !rst_wake;
          st_next.wake_rst = rst_wake;
        end
      end
      prmc_pkg::PRMC_STARTUP: begin
        if (stab_done && !st_reg.load) begin
          st_next.state = prmc_pkg::PRMC_RUN;
          st_next.pwr_ctrl[`PRMC_MODE_LSB +: 2] = 2'h0;
        end
      end
      default: st_next.state = prmc_pkg::PRMC_RUN;
    endcase
    st_next.cpu_clk_en = (st_next.state == prmc_pkg::PRMC_RUN);
    st_next.periph_clk_en = (st_next.state != prmc_pkg::PRMC_DOWN) &&
                            (st_next.state != prmc_pkg::PRMC_STARTUP);
    st_next.osc_en = (st_next.state != prmc_pkg::PRMC_DOWN);
    st_next.rc_osc_en = st_next.osc_en || (i_clk_sel_rc && i_rtc_enabled);
    st_next.wdt_run = st_next.osc_en || i_wdt_clk_sel;
    st_next.rtc_run = st_next.osc_en || !st_reg.pwr_ctrl_a[`PRMC_RTC_PD_BIT];
    st_next.cmp_power = cmp_on;
    st_next.bod_active = bod_on;
  end

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      st_reg <= '0;
      st_reg.pwr_ctrl <= `PRMC_PWR_CTRL_RST;
      st_reg.pwr_ctrl_a <= `PRMC_PWR_CTRL_A_RST;
      st_reg.wake_en <= `PRMC_WAKE_EN_RST;
      st_reg.state <= prmc_pkg::PRMC_RUN;
      st_reg.cpu_clk_en <= 1'b1;
      st_reg.periph_clk_en <= 1'b1;
      st_reg.osc_en <= 1'b1;
      st_reg.rc_osc_en <= 1'b1;
      st_reg.wdt_run <= 1'b1;
      st_reg.rtc_run <= 1'b1;
      st_reg.cmp_power <= 1'b1;
      st_reg.bod_active <= 1'b1;
    end else if (i_ce) begin
      st_reg <= st_next;
    end
  end

  assign o_prdata = st_reg.prdata;
  assign o_pready = st_reg.pready;
  assign o_pslverr = st_reg.pslverr;
  assign o_cpu_clk_en = st_reg.cpu_clk_en;
  assign o_osc_en = st_reg.osc_en;
  assign o_rc_osc_en = st_reg.rc_osc_en;
  assign o_periph_clk_en = st_reg.periph_clk_en;
  assign o_wdt_run = st_reg.wdt_run;
  assign o_cmp_power = st_reg.cmp_power;
  assign o_rtc_run = st_reg.rtc_run;
  assign o_bod_active = st_reg.bod_active;
  assign o_wake_irq = st_reg.wake_irq;
  assign o_wake_rst = st_reg.wake_rst;

  chk_idle_halts_cpu: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    st_reg.state == prmc_pkg::PRMC_IDLE |-> !o_cpu_clk_en && o_periph_clk_en)
    else $error("idle state with cpu clock running");
  chk_down_stops_osc: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    st_reg.state == prmc_pkg::PRMC_DOWN |-> !o_osc_en && !o_cpu_clk_en)
    else $error("power-down with oscillator running");
  chk_mode_enters_idle: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    i_ce && st_reg.state == prmc_pkg::PRMC_RUN && mode == 2'h1
    |=> st_reg.state == prmc_pkg::PRMC_IDLE)
    else $error("idle mode not entered");
  chk_idle_wake_exit: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    i_ce && st_reg.state == prmc_pkg::PRMC_IDLE && (irq_wake || rst_wake)
    |=> st_reg.state == prmc_pkg::PRMC_RUN && o_cpu_clk_en)
    else $error("idle not ended by wake source");
  chk_gie_gates_irq: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    i_ce && (st_reg.state == prmc_pkg::PRMC_IDLE || st_reg.state == prmc_pkg::PRMC_DOWN) &&
    !st_reg.wake_en[GIE_BIT] && !rst_wake |=> !o_wake_irq && !o_cpu_clk_en)
    else $error("interrupt wake without global enable");
  chk_down_wake_load: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    i_ce && st_reg.state == prmc_pkg::PRMC_DOWN && (irq_wake || rst_wake)
    |=> st_reg.state == prmc_pkg::PRMC_STARTUP && st_reg.load && o_osc_en)
    else $error("power-down wake did not restart oscillator");
  chk_stab_holds_cpu: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    st_reg.state == prmc_pkg::PRMC_STARTUP && !stab_done |-> !o_cpu_clk_en)
    else $error("cpu ran before oscillator stable");
  chk_total_pd_bod: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    i_ce && total_pd |=> !o_bod_active && !o_cmp_power)
    else $error("brownout or comparators on in total power-down");
  chk_pd_bod_kept: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    i_ce && mode == 2'h2 && !st_reg.pwr_ctrl[`PRMC_BOPD_BIT] |=> o_bod_active)
    else $error("brownout lost in power-down");
  chk_wdt_runs_pd: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    i_ce && i_wdt_clk_sel |=> o_wdt_run)
    else $error("watchdog stopped with clock select set");
  cov_idle_wake: cover property (@(posedge i_clk) disable iff (!i_arst_n)
    st_reg.state == prmc_pkg::PRMC_IDLE ##1 st_reg.state == prmc_pkg::PRMC_RUN);
  cov_pd_wake: cover property (@(posedge i_clk) disable iff (!i_arst_n)
    st_reg.state == prmc_pkg::PRMC_STARTUP ##1 st_reg.state == prmc_pkg::PRMC_RUN);
  cov_total_pd: cover property (@(posedge i_clk) disable iff (!i_arst_n)
    st_reg.state == prmc_pkg::PRMC_DOWN && total_pd);
endmodule

// File: design/prmc_stab_timer.sv
// oscillator stabilisation counter: counts a load value down to zero
// assumes one clock domain with enable and asynchronous reset
`timescale 1ns/1ps
`include "prmc_map.svh"
module prmc_stab_timer #(
  parameter int CNT_W = `PRMC_CNT_W
) (
  input wire logic i_clk,
  input wire logic i_arst_n,
  input wire logic i_ce,
  input wire logic i_load,
  input wire logic [CNT_W-1:0] i_load_val,
  output logic o_done
);
  typedef struct packed {
    logic [CNT_W-1:0] cnt;
    logic busy;
  } prmc_tmr_t;
  prmc_tmr_t st_reg;
  prmc_tmr_t st_next;

  if (CNT_W < 1) begin
    $error("CNT_W must be at least 1");
  end

  always_comb begin
    st_next = st_reg;
    if (i_load) begin
      st_next.cnt = i_load_val;
      st_next.busy = 1'b1;
    end else if (st_reg.busy) begin
      if (st_reg.cnt <= CNT_W'(1)) begin
        st_next.busy = 1'b0;
        st_next.cnt = '0;
      end else begin
        st_next.cnt = st_reg.cnt - CNT_W'(1);
      end
    end
  end

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      st_reg <= '0;
    end else if (i_ce) begin
      st_reg <= st_next;
    end
  end

  assign o_done = !st_reg.busy;
endmodule

// File: shared/prmc_map.svh
// register offsets, field positions, reset values and timing counts
// of the power reduction mode controller; definitions only
`ifndef PRMC_MAP_SVH
`define PRMC_MAP_SVH
`define PRMC_PWR_CTRL_OFS 12'h000
`define PRMC_PWR_CTRL_A_OFS 12'h004
`define PRMC_WAKE_EN_OFS 12'h008
`define PRMC_STATUS_OFS 12'h00c
`define PRMC_PWR_CTRL_RST 8'h00
`define PRMC_PWR_CTRL_A_RST 8'h00
`define PRMC_WAKE_EN_RST 16'h0000
`define PRMC_MODE_LSB 0
`define PRMC_BOPD_BIT 5
`define PRMC_CMP_PD_BIT 5
`define PRMC_RTC_PD_BIT 7
`define PRMC_XTAL_CYCLES 1024
`define PRMC_RC_CYCLES 256
`define PRMC_CNT_W 11
`define PRMC_STAT_DONE_BIT 2
`define PRMC_WAKE_EXT_BIT 0
`define PRMC_WAKE_KBD_BIT 1
`define PRMC_WAKE_RTC_BIT 2
`define PRMC_WAKE_WDI_BIT 3
`define PRMC_WAKE_BOI_BIT 4
`define PRMC_WAKE_CMP_BIT 5
`define PRMC_WAKE_WDR_BIT 6
`define PRMC_WAKE_BOR_BIT 7
`define PRMC_WAKE_XRS_BIT 8
`define PRMC_GIE_BIT 15
`endif

// File: shared/prmc_pkg.sv
// types of the power reduction mode controller
package prmc_pkg;
  typedef enum logic [1:0] {
    PRMC_MODE_NORMAL = 2'h0,
    PRMC_MODE_IDLE = 2'h1,
    PRMC_MODE_PD = 2'h2,
    PRMC_MODE_TOTAL_PD = 2'h3
  } prmc_mode_t;
  typedef enum logic [1:0] {
    PRMC_RUN,
    PRMC_IDLE,
    PRMC_DOWN,
    PRMC_STARTUP
  } prmc_state_t;
endpackage

// File: tb/prmc_wake_model.sv
// wake source model: turns one-cycle requests into held levels
// assumes requests come only while the cpu clock is stopped
`timescale 1ns/1ps
module prmc_wake_model (
  input wire logic i_clk,
  input wire logic i_arst_n,
  input wire logic [8:0] i_fire,
  input wire logic i_cpu_clk_en,
  output logic [8:0] o_src
);
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_src <= 9'h000;
    end else begin
      o_src <= (o_src | i_fire) & {9{~i_cpu_clk_en}};
    end
  end
endmodule

// File: tb/test_power_reduction_mode_control.sv
// self-checking bench: apb master, wake sources, queued result checks
// assumes the controller is built with short stabilisation counts
`timescale 1ns/1ps
`include "prmc_map.svh"
module test_power_reduction_mode_control;
  localparam int XT = 16;
  localparam int RC = 8;
  logic i_clk = 1'b0;
  logic i_arst_n = 1'b0;
  logic i_ce = 1'b1;
  logic i_psel = 1'b0;
  logic i_penable = 1'b0;
  logic i_pwrite = 1'b0;
  logic [11:0] i_paddr = 12'h000;
  logic [31:0] i_pwdata = 32'h0;
  logic i_wdt_clk_sel = 1'b0;
  logic i_rtc_enabled = 1'b0;
  logic i_clk_sel_rc = 1'b0;
  logic i_clk_sel_xtal = 1'b0;
  logic i_cmp_enabled = 1'b0;
  logic i_bod_int_sel = 1'b0;
  logic [8:0] fire = 9'h000;
  logic [8:0] src;
  logic [31:0] o_prdata;
  logic o_pready, o_pslverr, o_cpu_clk_en, o_osc_en, o_rc_osc_en, o_periph_clk_en;
  logic o_wdt_run, o_cmp_power, o_rtc_run, o_bod_active, o_wake_irq, o_wake_rst;
  int num_errors = 0;
  int compares = 0;
  int seed = 39121;
  int n;
  logic [31:0] r;
  logic [32:0] e;
  logic [32:0] rq[$];
  logic [1:0] wq[$];

  always #20 i_clk = ~i_clk;

  prmc_ctrl #(.XTAL_CYCLES(XT), .RC_CYCLES(RC)) prmc_ctrl_inst (
    .i_clk, .i_arst_n, .i_ce, .i_psel, .i_penable, .i_pwrite, .i_paddr, .i_pwdata,
    .o_prdata, .o_pready, .o_pslverr, .i_ext_int_pins(src[0]), .i_kbd_int(src[1]),
    .i_rtc_int(src[2]), .i_wdt_int(src[3]), .i_wdt_rst(src[6]),
    .i_bod_event(src[4] | src[7]), .i_cmp_int(src[5]), .i_ext_rst(src[8]),
    .i_wdt_clk_sel, .i_rtc_enabled, .i_clk_sel_rc, .i_clk_sel_xtal, .i_cmp_enabled,
    .i_bod_int_sel, .o_cpu_clk_en, .o_osc_en, .o_rc_osc_en, .o_periph_clk_en,
    .o_wdt_run, .o_cmp_power, .o_rtc_run, .o_bod_active, .o_wake_irq, .o_wake_rst);

  prmc_wake_model prmc_wake_model_inst (.i_clk, .i_arst_n, .i_fire(fire),
    .i_cpu_clk_en(o_cpu_clk_en), .o_src(src));

  task automatic stop_test();
    $display("errors %0d compares %0d", num_errors, compares);
    if (num_errors == 0 && compares > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  task automatic cmp(input logic [32:0] got, input logic [32:0] exp);
    compares++;
    if (got !== exp) begin
      num_errors++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int k;
    @(posedge i_clk);
    i_psel <= 1'b1;
    i_pwrite <= wr;
    i_paddr <= a;
    i_pwdata <= d;
    @(posedge i_clk);
    i_penable <= 1'b1;
    k = 0;
    do begin
      @(posedge i_clk);
      k++;
    end while (o_pready !== 1'b1 && k < 20);
    if (o_pready !== 1'b1) begin
      num_errors++;
      stop_test();
    end else begin
      i_psel <= 1'b0;
      i_penable <= 1'b0;
    end
  endtask

  task automatic rd(input logic [11:0] a, input logic [32:0] x);
    rq.push_back(x);
    apb(1'b0, a, 32'h0);
  endtask

  task automatic wait_run();
    n = 0;
    do begin
      @(posedge i_clk);
      n++;
    end while (o_cpu_clk_en !== 1'b1 && n < 200);
    if (o_cpu_clk_en !== 1'b1) begin
      num_errors++;
      stop_test();
    end
  endtask

  task automatic kick(input int s);
    @(posedge i_clk);
    fire <= 9'(1 << s);
    @(posedge i_clk);
    fire <= 9'h000;
  endtask

  // result monitor: read answers and wake pulses against queued notes
  always @(posedge i_clk) begin
    if (i_psel && i_penable && o_pready === 1'b1 && !i_pwrite) begin
      e = rq.pop_front();
      if (e[32]) begin
        cmp(33'(o_pslverr), 33'h1);
      end else begin
        cmp({o_pslverr, o_prdata}, e);
      end
    end
    if (o_wake_irq === 1'b1 || o_wake_rst === 1'b1) begin
      cmp(33'({o_wake_irq, o_wake_rst}), 33'(wq.size() > 0 ? wq.pop_front() : 2'b00));
    end
  end

  initial begin
    repeat (6) @(posedge i_clk);
    i_arst_n <= 1'b1;
    @(negedge i_clk);
    cmp(33'({o_cpu_clk_en, o_osc_en, o_periph_clk_en, o_rc_osc_en, o_wdt_run, o_cmp_power,
             o_rtc_run, o_bod_active}), 33'hff);
    rd(`PRMC_PWR_CTRL_OFS, 33'h0);
    rd(`PRMC_PWR_CTRL_A_OFS, 33'h0);
    rd(`PRMC_WAKE_EN_OFS, 33'h0);
    rd(12'h010, {1'b1, 32'h0});
    rd(`PRMC_STATUS_OFS, 33'h4);
    apb(1'b1, `PRMC_PWR_CTRL_OFS, 32'h2c);
    rd(`PRMC_PWR_CTRL_OFS, 33'h2c);
    @(negedge i_clk);
    cmp(33'({o_cpu_clk_en, o_bod_active}), 33'h2);
    apb(1'b1, `PRMC_PWR_CTRL_OFS, 32'h0);
    // idle with global enable off, then on
    apb(1'b1, `PRMC_WAKE_EN_OFS, 32'h0002);
    apb(1'b1, `PRMC_PWR_CTRL_OFS, 32'h1);
    repeat (3) @(negedge i_clk);
    cmp(33'({o_cpu_clk_en, o_osc_en, o_periph_clk_en}), 33'h3);
    kick(1);
    repeat (10) @(negedge i_clk);
    cmp(33'(o_cpu_clk_en), 33'h0);
    wq.push_back(2'b10);
    apb(1'b1, `PRMC_WAKE_EN_OFS, 32'h8002);
    wait_run();
    rd(`PRMC_PWR_CTRL_OFS, 33'h0);
    // idle ended by an enabled reset source
    apb(1'b1, `PRMC_WAKE_EN_OFS, 32'h0100);
    apb(1'b1, `PRMC_PWR_CTRL_OFS, 32'h1);
    repeat (3) @(negedge i_clk);
    wq.push_back(2'b01);
    kick(8);
    wait_run();
    cmp(33'(n <= 6), 33'h1);
    // power-down woken by each source in turn
    for (int i = 0; i < 9; i++) begin
      r = $random(seed);
      if (i == 5) r[4] = 1'b0;
      if (i == 2) r[3] = 1'b0;
      if (i == 3 || i == 6) r[0] = 1'b1;
      i_clk_sel_xtal <= i[0];
      i_clk_sel_rc <= ~i[0];
      i_wdt_clk_sel <= r[0];
      i_rtc_enabled <= r[1];
      i_cmp_enabled <= r[2];
      i_bod_int_sel <= (i != 7);
      apb(1'b1, `PRMC_PWR_CTRL_A_OFS, {24'h0, r[3], 1'b0, r[4], 5'h0});
      apb(1'b1, `PRMC_WAKE_EN_OFS, 32'h8000 | (32'h1 << i));
      apb(1'b1, `PRMC_PWR_CTRL_OFS, 32'h2);
      repeat (3) @(negedge i_clk);
      cmp(33'({o_cpu_clk_en, o_osc_en, o_periph_clk_en, o_bod_active}), 33'h1);
      cmp(33'(o_rc_osc_en), 33'(~i[0] & r[1]));
      cmp(33'({o_wdt_run, o_rtc_run, o_cmp_power}), 33'({r[0], ~r[3], ~(r[4] & ~r[2])}));
      wq.push_back(i < 6 ? 2'b10 : 2'b01);
      kick(i);
      wait_run();
      cmp(33'(n >= (i[0] ? XT : RC) && n <= (i[0] ? XT : RC) + 8), 33'h1);
    end
    // total power-down ignores brownout and comparator
    apb(1'b1, `PRMC_WAKE_EN_OFS, 32'h80b2);
    apb(1'b1, `PRMC_PWR_CTRL_OFS, 32'h3);
    repeat (3) @(negedge i_clk);
    cmp(33'({o_cpu_clk_en, o_bod_active, o_cmp_power}), 33'h0);
    kick(4);
    kick(5);
    repeat (20) @(negedge i_clk);
    cmp(33'(o_cpu_clk_en), 33'h0);
    wq.push_back(2'b10);
    @(posedge i_clk);
    i_ce <= 1'b0;
    kick(1);
    repeat (10) @(negedge i_clk);
    cmp(33'(o_cpu_clk_en), 33'h0);
    @(posedge i_clk);
    i_ce <= 1'b1;
    wait_run();
    cmp(33'(wq.size()), 33'h0);
    stop_test();
  end
endmodule
